// *** logic/storage_card_read_command_engine.sv ***
// Purpose: Read-family command execution behind the task-file registers
// Assumes: Host and media logic share mclk; media fills the buffer first
// Notes: Buffer holds one block of sectors, up to 2**SlotW of them
`timescale 1ns/1ns
// Behaviour
// - Key material read is B9h, feature 80h
// - Key read count 1-256, zero means 256
// - Key offset is cylinder-low:sector-number
// - Uncorrectable key error keeps failing offset
// - Value change needs feature 81h, B26Eh
// - Command 00h always aborts
// - E4h returns buffer like single read
// - Long read returns 516 bytes per sector
// - Long read skips ECC error reporting
// - 512 bytes as words, 4 as bytes
// - Long read is one sector only
// - Multiple read interrupts per block
// - Block size one accepted, larger optional
// - Request gates only at block start
// - Remainder sectors form final partial block
// - Multiple read aborts when not enabled
// - Errors posted at block start, block sent
// - Interrupt together with data request rise
// - Address shows last sector on success
// - Error stops address at failing sector
// - Only correctable errors continue further blocks
// - Busy, fill, request, clear busy, interrupt
module storage_card_read_command_engine #(
  parameter int SlotW = 2
) (
  input wire logic mclk,
  input wire logic rstn,
  input wire logic cmdValid,
  input wire logic [7:0] cmdCode,
  input wire logic [7:0] feature,
  input wire logic [7:0] secCount,
  input wire logic [7:0] secNum,
  input wire logic [7:0] cylLow,
  input wire logic [7:0] cylHigh,
  input wire logic [3:0] head,
  input wire logic kmSupported,
  input wire logic multEnabled,
  input wire logic [7:0] multBlockSize,
  output logic busy,
  output logic drq,
  output logic intrq,
  output logic errStatus,
  output logic errAbort,
  output logic errUnc,
  output logic errCorr,
  output logic [7:0] secNumOut,
  output logic [7:0] cylLowOut,
  output logic [7:0] cylHighOut,
  output logic [3:0] headOut,
  output logic kmChange,
  input wire logic dataRd,
  output logic [15:0] dataOut,
  output logic dataValid,
  output logic byteMode,
  output logic mediaReq,
  output logic [27:0] mediaLba,
  output logic [SlotW-1:0] mediaSlot,
  output logic mediaKeyArea,
  output logic mediaRaw,
  input wire logic mediaWrEn,
  input wire logic [8:0] mediaWrWord,
  input wire logic [15:0] mediaWrData,
  input wire logic mediaDone,
  input wire logic mediaUnc,
  input wire logic mediaCorr
);
  localparam int AW = SlotW + rd_cmd_pkg::WORD_AW;
  localparam int MaxBlk = 1 << SlotW;

  typedef enum logic [2:0] {ST_IDLE, ST_FETCH_REQ, ST_FETCH_WAIT, ST_XFER, ST_DONE} state_t;
  typedef enum logic [1:0] {K_KEY, K_LONG, K_MULT, K_BUF} kind_t;

  state_t stateQ;
  kind_t kindQ;
  logic [8:0] remainQ;
  logic [SlotW:0] blkSizeQ;
  logic [SlotW:0] fillQ;
  logic [SlotW:0] rdSlotQ;
  logic [7:0] wordQ;
  logic eccQ;
  logic [1:0] byteQ;
  logic stopQ;
  logic blkUncQ;
  logic blkCorrQ;
  logic [27:0] curAddrQ;
  logic [27:0] lastAddrQ;
  logic intrQ;
  logic kmChangeQ;
  logic errAbortQ;
  logic errUncQ;
  logic errCorrQ;
  logic rdPipeQ;
  logic [1:0] byteSelQ;
  logic [15:0] dataOutQ;
  logic dataValidQ;

  logic take;
  logic isKm;
  logic kmRead;
  logic kmChg;
  logic multOk;
  logic isLong;
  logic isBuf;
  logic goodRead;
  logic blkFull;
  logic rdFire;
  logic lastUnit;
  logic endCmd;
  logic enterXfer;

  sector_buf_if #(.AW(AW)) bufBus ();

  sector_buffer u_buf (
    .mclk(mclk),
    .bus(bufBus.mem)
  );

  assign take = cmdValid && (stateQ == ST_IDLE);
  assign isKm = (cmdCode == rd_cmd_pkg::CMD_KEY_MGMT);
  assign kmRead = isKm && (feature == rd_cmd_pkg::FEAT_KEY_READ) && kmSupported;
  assign kmChg = isKm && (feature == rd_cmd_pkg::FEAT_KEY_CHANGE) && kmSupported
    && ({cylHigh, cylLow} == rd_cmd_pkg::KM_CHECK);
  // block sizes up to buffer capacity
  assign multOk = (cmdCode == rd_cmd_pkg::CMD_READ_MULT) && multEnabled
    && (multBlockSize != 8'h00) && (32'(multBlockSize) <= MaxBlk);
  assign isLong = (cmdCode == rd_cmd_pkg::CMD_READ_LONG)
    || (cmdCode == rd_cmd_pkg::CMD_READ_LONG_NR);
  assign isBuf = (cmdCode == rd_cmd_pkg::CMD_READ_BUF);
  assign goodRead = kmRead || multOk || isLong || isBuf;

  assign blkFull = ((fillQ + 1'b1) == blkSizeQ) || (remainQ == rd_cmd_pkg::ONE_SECTOR);
  assign rdFire = (stateQ == ST_XFER) && dataRd;
  // ECC bytes follow the data words
  assign lastUnit = rdFire && ((kindQ == K_LONG) ? (eccQ && byteQ == rd_cmd_pkg::ECC_BYTE_LAST)
    : (wordQ == rd_cmd_pkg::SECTOR_WORD_LAST && (rdSlotQ + 1'b1) == fillQ));
  assign endCmd = (remainQ == 9'h000) || stopQ;
  assign enterXfer = (stateQ == ST_FETCH_WAIT && mediaDone && blkFull) || (take && isBuf);

  // busy while filling, request once filled
  assign busy = (stateQ != ST_IDLE) && (stateQ != ST_XFER);
  // request held for the whole block
  assign drq = (stateQ == ST_XFER);
  assign mediaReq = (stateQ == ST_FETCH_REQ);
  assign mediaLba = curAddrQ;
  assign mediaSlot = fillQ[SlotW-1:0];
  assign mediaKeyArea = (kindQ == K_KEY);
  assign mediaRaw = (kindQ == K_LONG);

  assign bufBus.wrEn = mediaWrEn;
  assign bufBus.wrAddr = {fillQ[SlotW-1:0], mediaWrWord};
  assign bufBus.wrData = mediaWrData;
  assign bufBus.rdEn = rdFire;
  assign bufBus.rdAddr = eccQ ? {{SlotW{1'b0}}, rd_cmd_pkg::ECC_WORD_BASE + 9'(byteQ[1])}
    : {rdSlotQ[SlotW-1:0], 1'b0, wordQ};

  assign intrq = intrQ;
  assign kmChange = kmChangeQ;
  assign errAbort = errAbortQ;
  assign errUnc = errUncQ;
  assign errCorr = errCorrQ;
  assign errStatus = errAbortQ || errUncQ;
  assign secNumOut = lastAddrQ[7:0];
  assign cylLowOut = lastAddrQ[15:8];
  assign cylHighOut = lastAddrQ[23:16];
  assign headOut = lastAddrQ[27:24];
  assign dataOut = dataOutQ;
  assign dataValid = dataValidQ;
  assign byteMode = eccQ;

  always_ff @(posedge mclk) begin
    if (!rstn) begin
      stateQ <= ST_IDLE;
    end else begin
      case (stateQ)
        ST_IDLE: begin
          if (cmdValid) begin
            stateQ <= goodRead ? (isBuf ? ST_XFER : ST_FETCH_REQ) : ST_DONE;
          end
        end
        ST_FETCH_REQ: stateQ <= ST_FETCH_WAIT;
        ST_FETCH_WAIT: begin
          if (mediaDone) begin
            stateQ <= blkFull ? ST_XFER : ST_FETCH_REQ;
          end
        end
        ST_XFER: begin
          if (lastUnit) begin
            stateQ <= endCmd ? ST_IDLE : ST_FETCH_REQ;
          end
        end
        ST_DONE: stateQ <= ST_IDLE;
        default: stateQ <= ST_IDLE;
      endcase
    end
  end

  // Command kind, counts and block size
  always_ff @(posedge mclk) begin
    if (!rstn) begin
      kindQ <= K_BUF;
      remainQ <= 9'h000;
      blkSizeQ <= '0;
    end else if (take) begin
      kindQ <= multOk ? K_MULT : (isLong ? K_LONG : (isBuf ? K_BUF : K_KEY));
      blkSizeQ <= multOk ? (SlotW + 1)'(multBlockSize) : (SlotW + 1)'(1);
      if (isBuf) begin
        remainQ <= 9'h000;
      end else if (isLong) begin
        remainQ <= rd_cmd_pkg::ONE_SECTOR;
      end else begin
        remainQ <= (secCount == 8'h00) ? rd_cmd_pkg::MAX_SECTORS : {1'b0, secCount};
      end
    end else if (stateQ == ST_FETCH_WAIT && mediaDone) begin
      remainQ <= remainQ - 1'b1;
    end
  end

  // Sectors filled in the current block
  always_ff @(posedge mclk) begin
    if (!rstn) begin
      fillQ <= '0;
    end else if (take) begin
      fillQ <= isBuf ? (SlotW + 1)'(1) : '0;
    end else if (stateQ == ST_FETCH_WAIT && mediaDone) begin
      fillQ <= fillQ + 1'b1;
    end else if (lastUnit) begin
      fillQ <= '0;
    end
  end

  // 256 words plus 4 bytes for long
  always_ff @(posedge mclk) begin
    if (!rstn) begin
      wordQ <= 8'h00;
      rdSlotQ <= '0;
      eccQ <= 1'b0;
      byteQ <= 2'h0;
    end else if (take || lastUnit) begin
      wordQ <= 8'h00;
      rdSlotQ <= '0;
      eccQ <= 1'b0;
      byteQ <= 2'h0;
    end else if (rdFire) begin
      if (eccQ) begin
        byteQ <= byteQ + 1'b1;
      end else if (wordQ == rd_cmd_pkg::SECTOR_WORD_LAST) begin
        wordQ <= 8'h00;
        if (kindQ == K_LONG) begin
          eccQ <= 1'b1;
        end else begin
          rdSlotQ <= rdSlotQ + 1'b1;
        end
      end else begin
        wordQ <= wordQ + 1'b1;
      end
    end
  end

  // address from head:cylinder:sector, key offset from cylinder-low and sector number
  always_ff @(posedge mclk) begin
    if (!rstn) begin
      curAddrQ <= '0;
      lastAddrQ <= '0;
    end else if (take && goodRead && !isBuf) begin
      curAddrQ <= kmRead ? 28'({cylLow, secNum}) : {head, cylHigh, cylLow, secNum};
      lastAddrQ <= kmRead ? 28'({cylLow, secNum}) : {head, cylHigh, cylLow, secNum};
    end else if (stateQ == ST_FETCH_WAIT && mediaDone) begin
      curAddrQ <= curAddrQ + 1'b1;
      if (!stopQ) begin
        lastAddrQ <= curAddrQ;
      end
    end
  end

  // stop after the block on hard error
  always_ff @(posedge mclk) begin
    if (!rstn) begin
      stopQ <= 1'b0;
      blkUncQ <= 1'b0;
      blkCorrQ <= 1'b0;
    end else if (take) begin
      stopQ <= 1'b0;
      blkUncQ <= 1'b0;
      blkCorrQ <= 1'b0;
    end else if (stateQ == ST_FETCH_WAIT && mediaDone && kindQ != K_LONG) begin
      stopQ <= stopQ || mediaUnc;
      blkUncQ <= blkUncQ || mediaUnc;
      blkCorrQ <= blkCorrQ || (mediaCorr && !mediaUnc);
    end else if (stateQ == ST_XFER) begin
      blkUncQ <= 1'b0;
      blkCorrQ <= 1'b0;
    end
  end

  // errors posted as the block opens
  always_ff @(posedge mclk) begin
    if (!rstn) begin
      errAbortQ <= 1'b0;
      errUncQ <= 1'b0;
      errCorrQ <= 1'b0;
    end else if (take) begin
      errAbortQ <= !goodRead && !kmChg;
      errUncQ <= 1'b0;
      errCorrQ <= 1'b0;
    end else if (enterXfer) begin
      errUncQ <= errUncQ || blkUncQ || (mediaDone && mediaUnc && kindQ != K_LONG);
      errCorrQ <= errCorrQ || blkCorrQ
        || (mediaDone && mediaCorr && !mediaUnc && kindQ != K_LONG);
    end
  end

  // interrupt with request rise or end
  always_ff @(posedge mclk) begin
    if (!rstn) begin
      intrQ <= 1'b0;
      kmChangeQ <= 1'b0;
    end else begin
      intrQ <= enterXfer || (stateQ == ST_DONE);
      kmChangeQ <= take && kmChg;
    end
  end

  always_ff @(posedge mclk) begin
    if (!rstn) begin
      rdPipeQ <= 1'b0;
      byteSelQ <= 2'h0;
      dataOutQ <= 16'h0000;
      dataValidQ <= 1'b0;
    end else begin
      rdPipeQ <= rdFire;
      byteSelQ <= {eccQ, byteQ[0]};
      dataValidQ <= rdPipeQ;
      if (rdPipeQ) begin
        if (byteSelQ[1]) begin
          dataOutQ <= {8'h00, byteSelQ[0] ? bufBus.rdData[15:8] : bufBus.rdData[7:0]};
        end else begin
          dataOutQ <= bufBus.rdData;
        end
      end
    end
  end

  nop_abort_a: assert property (@(posedge mclk) disable iff (!rstn)
    take && cmdCode == rd_cmd_pkg::CMD_NOP |=> errAbort && busy ##1 intrq && !busy)
    else $error("nop did not abort");

  km_absent_a: assert property (@(posedge mclk) disable iff (!rstn)
    take && isKm && !kmSupported |=> errAbort ##1 intrq && !kmChange)
    else $error("key command without scheme not aborted");

  km_check_a: assert property (@(posedge mclk) disable iff (!rstn)
    kmChange |-> $past({cylHigh, cylLow}) == rd_cmd_pkg::KM_CHECK && !errAbort)
    else $error("value change without check value");

  mult_abort_a: assert property (@(posedge mclk) disable iff (!rstn)
    take && cmdCode == rd_cmd_pkg::CMD_READ_MULT && !multEnabled
    |=> errAbort && !drq ##1 intrq && stateQ == ST_IDLE)
    else $error("disabled multiple read not aborted");

  drq_intr_a: assert property (@(posedge mclk) disable iff (!rstn)
    $rose(drq) |-> intrq && !busy)
    else $error("request rose without interrupt");

  key_count_a: assert property (@(posedge mclk) disable iff (!rstn)
    take && kmRead && secCount == 8'h00 |=> remainQ == rd_cmd_pkg::MAX_SECTORS && busy)
    else $error("zero count not read as 256");

  long_clean_a: assert property (@(posedge mclk) disable iff (!rstn)
    drq && kindQ == K_LONG |-> !errUnc && !errCorr)
    else $error("long read reported ECC error");

  long_single_a: assert property (@(posedge mclk) disable iff (!rstn)
    lastUnit && kindQ == K_LONG |=> stateQ == ST_IDLE && !drq)
    else $error("long read ran past one sector");

  byte_mode_a: assert property (@(posedge mclk) disable iff (!rstn)
    byteMode |-> kindQ == K_LONG && wordQ == 8'h00 && drq)
    else $error("byte mode outside long ECC phase");

  block_fill_a: assert property (@(posedge mclk) disable iff (!rstn)
    $rose(drq) && kindQ == K_MULT |-> fillQ == blkSizeQ || (remainQ == 9'h000 && fillQ < blkSizeQ))
    else $error("block size wrong at request");

  err_addr_a: assert property (@(posedge mclk) disable iff (!rstn)
    stopQ && mediaDone && stateQ == ST_FETCH_WAIT |=> lastAddrQ == $past(lastAddrQ))
    else $error("address moved after error");
endmodule // storage_card_read_command_engine

// *** inc/rd_cmd_pkg.sv ***
// Purpose: Shared constants for the read command engine and its buffer
// Assumes: Task-file registers arrive as 8-bit values on one clock
// Notes: Command and feature codes, check value and buffer geometry
package rd_cmd_pkg;
  localparam logic [7:0] CMD_NOP = 8'h00;
  localparam logic [7:0] CMD_KEY_MGMT = 8'hb9;
  localparam logic [7:0] CMD_READ_BUF = 8'he4;
  localparam logic [7:0] CMD_READ_LONG = 8'h22;
  localparam logic [7:0] CMD_READ_LONG_NR = 8'h23;
  localparam logic [7:0] CMD_READ_MULT = 8'hc4;
  localparam logic [7:0] FEAT_KEY_READ = 8'h80;
  localparam logic [7:0] FEAT_KEY_CHANGE = 8'h81;
  localparam logic [15:0] KM_CHECK = 16'hb26e;
  localparam int LBA_W = 28;
  localparam int WORD_AW = 9;
  localparam logic [7:0] SECTOR_WORD_LAST = 8'hff;
  localparam logic [8:0] ECC_WORD_BASE = 9'h100;
  localparam logic [1:0] ECC_BYTE_LAST = 2'h3;
  localparam logic [8:0] MAX_SECTORS = 9'h100;
  localparam logic [8:0] ONE_SECTOR = 9'h001;
endpackage

// *** inc/sector_buf_if.sv ***
// Purpose: Write and read ports between the engine and its sector buffer
// Assumes: One clock; read data registered in the buffer
// Notes: AW covers slot index plus word index
`timescale 1ns/1ns
interface sector_buf_if #(
  parameter int AW = 11
);
  logic wrEn;
  logic [AW-1:0] wrAddr;
  logic [15:0] wrData;
  logic rdEn;
  logic [AW-1:0] rdAddr;
  logic [15:0] rdData;
  modport engine (output wrEn, wrAddr, wrData, rdEn, rdAddr, input rdData);
  modport mem (input wrEn, wrAddr, wrData, rdEn, rdAddr, output rdData);
endinterface

// *** logic/sector_buffer.sv ***
// Purpose: Sector buffer memory, one write and one registered read port
// Assumes: Depth is two to the address width
// Notes: Contents are not reset
`timescale 1ns/1ns
module sector_buffer (
  input wire logic mclk,
  sector_buf_if.mem bus
);
  localparam int Depth = 1 << $bits(bus.rdAddr);
  logic [15:0] mem [Depth];

  always_ff @(posedge mclk) begin
    if (bus.wrEn) begin
      mem[bus.wrAddr] <= bus.wrData;
    end
  end

  always_ff @(posedge mclk) begin
    if (bus.rdEn) begin
      bus.rdData <= mem[bus.rdAddr];
    end
  end
endmodule // sector_buffer

// *** testbench/media_model.sv ***
// Purpose: Media side model that fills the sector buffer
// Assumes: One sector outstanding, random fetch latency
// Notes: Error flags raised when the fetched address matches
`timescale 1ns/1ns
module media_model (
  input wire logic mclk,
  input wire logic rstn,
  input wire logic mediaReq,
  input wire logic [27:0] mediaLba,
  input wire logic mediaKeyArea,
  input wire logic [27:0] uncLba,
  input wire logic [27:0] corrLba,
  output logic mediaWrEn,
  output logic [8:0] mediaWrWord,
  output logic [15:0] mediaWrData,
  output logic mediaDone,
  output logic mediaUnc,
  output logic mediaCorr
);
  logic act;
  logic key;
  logic [27:0] lba;
  int dly;
  int idx;
  always @(posedge mclk) begin
    mediaDone <= 1'b0;
    mediaUnc <= 1'b0;
    mediaCorr <= 1'b0;
    mediaWrEn <= 1'b0;
    mediaWrData <= ~mediaWrData;
    if (!rstn) begin
      act <= 1'b0;
      mediaWrData <= 16'h0000;
      mediaWrWord <= 9'h000;
    end else if (mediaReq) begin
      act <= 1'b1;
      lba <= mediaLba;
      key <= mediaKeyArea;
      dly <= $urandom_range(4, 1);
      idx <= 0;
    end else if (act && dly > 0) begin
      dly <= dly - 1;
    end else if (act && idx < 258) begin
      mediaWrEn <= 1'b1;
      mediaWrWord <= idx[8:0];
      mediaWrData <= (lba[15:0] + 16'(idx) * 16'h0101) ^ {key, 15'h0000};
      idx <= idx + 1;
    end else if (act) begin
      act <= 1'b0;
      mediaDone <= 1'b1;
      mediaUnc <= lba == uncLba;
      mediaCorr <= lba == corrLba;
    end
  end
endmodule // media_model

// *** testbench/storage_card_read_command_engine_test.sv ***
// Purpose: Self-checking bench for the read command engine
// Assumes: Host inputs change on the falling edge
// Notes: Expected data rebuilt from the media fill pattern
`timescale 1ns/1ns
module storage_card_read_command_engine_test;
  localparam int Limit = 20000;
  logic mclk = 1'b0;
  logic rstn = 1'b0;
  logic cmdValid = 1'b0;
  logic dataRd = 1'b0;
  logic kmSupported = 1'b1;
  logic multEnabled = 1'b1;
  logic [7:0] cmdCode = 8'h00;
  logic [7:0] feature = 8'h00;
  logic [7:0] secCount = 8'h00;
  logic [7:0] secNum = 8'h00;
  logic [7:0] cylLow = 8'h00;
  logic [7:0] cylHigh = 8'h00;
  logic [3:0] head = 4'h0;
  logic [7:0] multBlockSize = 8'h01;
  logic [27:0] uncLba = '1;
  logic [27:0] corrLba = '1;
  logic busy, drq, intrq, errStatus, errAbort, errUnc, errCorr, kmChange, drqPrev;
  logic dataValid, byteMode, mediaReq, mediaKeyArea, mediaRaw;
  logic mediaWrEn, mediaDone, mediaUnc, mediaCorr;
  logic [7:0] secNumOut, cylLowOut, cylHighOut;
  logic [3:0] headOut;
  logic [15:0] dataOut, mediaWrData;
  logic [27:0] mediaLba, lba;
  logic [1:0] mediaSlot;
  logic [8:0] mediaWrWord;
  logic [15:0] gotQ[$];
  int failCount = 0;
  int comparisons = 0;
  int cycles = 0;
  int intrCount = 0;
  int kmCount = 0;
  int irqMiss = 0;
  int slotSeen = 0;
  int slotBad = 0;
  int k0;
  always #2 mclk = ~mclk;
  storage_card_read_command_engine #(.SlotW(2)) dut (
    .mclk, .rstn, .cmdValid, .cmdCode, .feature, .secCount, .secNum, .cylLow,
    .cylHigh, .head, .kmSupported, .multEnabled, .multBlockSize, .busy, .drq,
    .intrq, .errStatus, .errAbort, .errUnc, .errCorr, .secNumOut, .cylLowOut,
    .cylHighOut, .headOut, .kmChange, .dataRd, .dataOut, .dataValid, .byteMode,
    .mediaReq, .mediaLba, .mediaSlot, .mediaKeyArea, .mediaRaw, .mediaWrEn,
    .mediaWrWord, .mediaWrData, .mediaDone, .mediaUnc, .mediaCorr);
  media_model media (.mclk, .rstn, .mediaReq, .mediaLba, .mediaKeyArea, .uncLba,
    .corrLba, .mediaWrEn, .mediaWrWord, .mediaWrData, .mediaDone, .mediaUnc,
    .mediaCorr);
  task automatic close_out();
    $display("counts comparisons %0d mismatches %0d", comparisons, failCount);
    if (failCount == 0 && comparisons > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  always @(negedge mclk) begin
    if (dataValid === 1'b1) gotQ.push_back(dataOut);
    if (intrq === 1'b1) intrCount++;
    if (kmChange === 1'b1) kmCount++;
    if (drq === 1'b1 && drqPrev !== 1'b1 && intrq !== 1'b1) irqMiss++;
    drqPrev = drq;
    if (mediaReq === 1'b1) begin
      if (mediaSlot !== 2'(slotSeen)) slotBad++;
      slotSeen++;
    end
    if (drq === 1'b1 || busy !== 1'b1) slotSeen = 0;
    cycles++;
    if (cycles == Limit) begin
      failCount++;
      close_out();
    end
  end
  task automatic chk_flag(input string n, input logic e, input logic g);
    comparisons++;
    if (g !== e) begin
      failCount++;
      $display("BAD %s expected %0h seen %0h", n, e, g);
    end
  endtask
  task automatic chk_val(input string n, input logic [27:0] e, input logic [27:0] g);
    comparisons++;
    if (g !== e) begin
      failCount++;
      $display("BAD %s expected %0h seen %0h", n, e, g);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(negedge mclk);
  endtask
  function automatic logic [15:0] pat(input logic [27:0] l, input int w, input logic k);
    return (l[15:0] + 16'(w) * 16'h0101) ^ {k, 15'h0000};
  endfunction
  task automatic issue(input logic [7:0] c, input logic [7:0] f, input logic [7:0] n,
      input logic [27:0] a);
    @(negedge mclk);
    {head, cylHigh, cylLow, secNum} = a;
    cmdCode = c;
    feature = f;
    secCount = n;
    cmdValid = 1'b1;
    @(negedge mclk);
    cmdValid = 1'b0;
  endtask
  task automatic wait_idle();
    int k;
    k = 0;
    while ((busy !== 1'b0 || drq !== 1'b0) && k < 3000) begin
      @(negedge mclk);
      k++;
    end
    chk_flag("idle", 1'b1, k < 3000);
  endtask
  task automatic rd_units(input int u);
    dataRd = 1'b1;
    tick(u);
    dataRd = 1'b0;
  endtask
  task automatic aborted(input logic [7:0] c, input logic [7:0] f, input logic [27:0] a);
    int k;
    k = kmCount;
    issue(c, f, 8'h01, a);
    chk_flag("busy", 1'b1, busy);
    chk_flag("errAbort", 1'b1, errAbort);
    chk_flag("errStatus", 1'b1, errStatus);
    @(negedge mclk);
    chk_flag("busy", 1'b0, busy);
    chk_flag("intrq", 1'b1, intrq);
    tick(2);
    chk_val("kmChange", k, kmCount);
    $display("test abort %h done", c);
  endtask
  task automatic run_read(input logic [7:0] c, input logic [7:0] f, input logic [7:0] n,
      input logic [27:0] a, input int bs, input int ue, input int ce, input int mode);
    logic [15:0] exp[$];
    logic [15:0] w;
    logic key;
    logic [27:0] ad;
    int tot, idx, sEnd, nb, stop, k, bad, i0;
    key = c == 8'hb9;
    tot = (mode > 0) ? 1 : (n == 8'h00) ? 256 : int'(n);
    uncLba = (ue >= 0) ? a + 28'(ue) : '1;
    corrLba = (ce >= 0) ? a + 28'(ce) : '1;
    gotQ.delete();
    i0 = intrCount;
    idx = 0;
    nb = 0;
    stop = 0;
    issue(c, f, n, a);
    while (idx < tot && stop == 0) begin
      sEnd = (idx + bs < tot) ? idx + bs : tot;
      k = 0;
      while (drq !== 1'b1 && k < 3000) begin
        @(negedge mclk);
        k++;
      end
      chk_flag("intrq", 1'b1, intrq);
      chk_flag("errUnc", mode == 0 && ue >= idx && ue < sEnd, errUnc);
      chk_flag("errCorr", mode == 0 && ce >= 0 && ce < sEnd, errCorr);
      chk_flag("mediaRaw", mode == 1, mediaRaw);
      for (int s = idx; s < sEnd; s++)
        for (int j = 0; j < 256; j++) exp.push_back(pat(a + 28'(s), j, key));
      rd_units((sEnd - idx) * 256);
      if (mode == 1) begin
        tick(3);
        chk_flag("byteMode", 1'b1, byteMode);
        for (int b = 0; b < 4; b++) begin
          w = pat(a, 256 + b / 2, 1'b0);
          exp.push_back({8'h00, (b % 2) ? w[15:8] : w[7:0]});
        end
        rd_units(4);
      end
      if (mode == 0 && ue >= idx && ue < sEnd) stop = 1;
      nb++;
      idx = sEnd;
    end
    wait_idle();
    tick(3);
    bad = 0;
    foreach (exp[i]) if (i >= gotQ.size() || gotQ[i] !== exp[i]) bad++;
    chk_val("words", exp.size(), gotQ.size());
    chk_val("badWords", 0, bad);
    chk_val("blocks", nb, intrCount - i0);
    chk_val("irqMiss", 0, irqMiss);
    if (key && stop == 1) chk_val("offset", a + 28'(ue), {cylLowOut, secNumOut});
    ad = {headOut, cylHighOut, cylLowOut, secNumOut};
    chk_val("slotBad", 0, slotBad);
    if (!key && mode < 2)
      chk_val("addr", a + 28'(stop ? ue : tot - 1), ad);
    $display("test read %h done", c);
  endtask
  task automatic key_zero(input logic [27:0] a);
    int k;
    issue(8'hb9, 8'h80, 8'h00, a);
    for (int s = 0; s < 2; s++) begin
      k = 0;
      while (drq !== 1'b1 && k < 3000) begin
        @(negedge mclk);
        k++;
      end
      chk_flag("drq", 1'b1, drq);
      if (s == 0) rd_units(256);
    end
    rstn = 1'b0;
    tick(2);
    chk_flag("drq", 1'b0, drq);
    rstn = 1'b1;
    @(negedge mclk);
    chk_flag("busy", 1'b0, busy);
    $display("test key count zero done");
  endtask
  initial begin
    lba = 28'($urandom(32'h0fbf) & 32'h0ffffff0);
    tick(8);
    rstn = 1'b1;
    aborted(8'h00, 8'h00, lba);
    aborted(8'hb9, 8'h81, 28'h00b26f00);
    k0 = kmCount;
    issue(8'hb9, 8'h81, 8'h00, 28'h00b26e00);
    chk_flag("errAbort", 1'b0, errAbort);
    wait_idle();
    tick(2);
    chk_val("kmChange", k0 + 1, kmCount);
    $display("test value change done");
    kmSupported = 1'b0;
    aborted(8'hb9, 8'h80, 28'h0);
    kmSupported = 1'b1;
    multEnabled = 1'b0;
    aborted(8'hc4, 8'h00, lba);
    multEnabled = 1'b1;
    multBlockSize = 8'h03;
    run_read(8'hc4, 8'h00, 8'h04, lba, 3, -1, 0, 0);
    multBlockSize = 8'h02;
    run_read(8'hc4, 8'h00, 8'h04, lba + 28'h10, 2, 1, -1, 0);
    multBlockSize = 8'h01;
    run_read(8'hc4, 8'h00, 8'h02, lba + 28'h20, 1, -1, -1, 0);
    run_read(8'hb9, 8'h80, 8'h02, 28'(lba[15:0]), 1, 1, -1, 0);
    run_read(8'h22, 8'h00, 8'h05, lba, 1, 0, -1, 1);
    run_read(8'h23, 8'h00, 8'h01, lba + 28'h30, 1, -1, -1, 1);
    run_read(8'he4, 8'h00, 8'h00, lba + 28'h30, 1, -1, -1, 2);
    key_zero(28'(lba[15:0]));
    aborted(8'hb9, 8'h82, lba);
    close_out();
  end
endmodule // storage_card_read_command_engine_test
